// [hdl/pes_event_regs.sv]
`timescale 1ns/1ps
module pes_event_regs (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire pes_pkg::pes_event_t event_i,
   input wire logic [7:0] otp_identity_i,
   input wire logic [7:0] otp_rail_one_i,
   output logic irq_o,
   output logic [6:0] rail_one_voltage_code_o,
   output logic rail_one_passive_fall_o
);

   logic [7:0] sync_in;
   logic [7:0] sync_out;
   logic scl_sync;
   logic sda_sync;
   pes_pkg::pes_event_t ev;
   pes_pkg::pes_event_t ev_prev_reg;
   pes_pkg::pes_event_t ev_rise;
   pes_pkg::pes_reg_wr_t wr;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   logic [7:0] masks_reg;
   logic [7:0] status_reg;
   logic [7:0] cause_reg;
   logic [7:0] cause_next;
   logic [7:0] cause_set;
   logic [7:0] flags_set;
   logic [7:0] flags_clr;
   logic [7:0] cause_clr;
   logic [7:0] rail_one_reg;
   logic rail_loaded_reg;
   logic [7:0] identity_reg;
   logic [1:0] settle_reg;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   assign sync_in = {scl_i, sda_i, event_i};
   // Bus lines read idle-high until the synchroniser has filled, so leaving reset fakes no bus edge
   assign scl_sync = sync_out[7] | ~settle_reg[1];
   assign sda_sync = sync_out[6] | ~settle_reg[1];
   assign ev = pes_pkg::pes_event_t'(sync_out[5:0]);
   assign sda_o = 1'b0;

   pes_sync #(
      .WIDTH(8)
   ) u_sync (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .async_i(sync_in),
      .sync_o(sync_out)
   );

   pes_i2c_target u_port (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .scl_i(scl_sync),
      .sda_i(sda_sync),
      .rd_data_i(rd_data),
      .sda_oe_o(sda_oe_o),
      .wr_o(wr),
      .rd_addr_o(rd_addr)
   );

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         settle_reg <= 2'h0;
      end else begin
         settle_reg <= {settle_reg[0], 1'b1};
      end
   end

   // Edge detect so a level that stays high sets a flag once, not again after each clear
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ev_prev_reg <= '0;
      end else begin
         ev_prev_reg <= ev;
      end
   end

   assign ev_rise = ev & ~ev_prev_reg;

   // Cause register: set wins over a simultaneous host clear
   always_comb begin
      cause_set = 8'h00;
      cause_set[pes_pkg::BIT_UV] = ev_rise.uv_off;
      cause_set[pes_pkg::BIT_OC] = ev_rise.oc_off;
      cause_set[pes_pkg::BIT_HEAT] = ev_rise.heat_off;
      cause_clr = (wr.wr_en && hit(wr.addr, pes_pkg::OFS_CAUSE)) ? wr.data : 8'h00;
      cause_next = (cause_set | (cause_reg & ~cause_clr)) & pes_pkg::CAUSE_USED;
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cause_reg <= pes_pkg::CAUSE_RESET;
      end else begin
         cause_reg <= cause_next;
      end
   end

   // Flags: shutdown flag clear is held off while any cause bit is still set
   always_comb begin
      flags_set = 8'h00;
      flags_set[pes_pkg::BIT_FAULT] = ev_rise.power_fault | ev_rise.crit_temp;
      flags_set[pes_pkg::BIT_POWER_OFF] = |cause_set;
      flags_set[pes_pkg::BIT_HOT_DIE] = ev_rise.hot_temp;
      flags_clr = (wr.wr_en && hit(wr.addr, pes_pkg::OFS_FLAGS)) ? wr.data : 8'h00;
      if (cause_reg != 8'h00) begin
         flags_clr[pes_pkg::BIT_POWER_OFF] = 1'b0;
      end
      flags_next = (flags_set | (flags_reg & ~flags_clr)) & pes_pkg::FLAGS_USED;
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         flags_reg <= pes_pkg::FLAGS_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Only the three implemented mask bits are writable; the rest stay at one
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         masks_reg <= pes_pkg::MASKS_RESET;
      end else if (wr.wr_en && hit(wr.addr, pes_pkg::OFS_MASKS)) begin
         masks_reg <= (wr.data & pes_pkg::FLAGS_USED) | ~pes_pkg::FLAGS_USED;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_reg <= pes_pkg::STATUS_RESET;
      end else begin
         status_reg <= {7'h00, ev.hot_temp};
      end
   end

   // Trimmed values are captured in the first cycle after reset release
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rail_loaded_reg <= 1'b0;
         rail_one_reg <= 8'h00;
         identity_reg <= 8'h00;
      end else if (!rail_loaded_reg) begin
         rail_loaded_reg <= 1'b1;
         rail_one_reg <= otp_rail_one_i;
         identity_reg <= otp_identity_i;
      end else if (wr.wr_en && hit(wr.addr, pes_pkg::OFS_RAIL_ONE)) begin
         rail_one_reg <= wr.data;
      end
   end

   assign rail_one_voltage_code_o = rail_one_reg[7:1];
   assign rail_one_passive_fall_o = rail_one_reg[0];

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(flags_reg & ~masks_reg & pes_pkg::FLAGS_USED);
      end
   end

   // Unmapped offsets read zero
   always_comb begin
      rd_data = 8'h00;
      if (hit(rd_addr, pes_pkg::OFS_IDENTITY)) begin
         rd_data = identity_reg;
      end else if (hit(rd_addr, pes_pkg::OFS_FLAGS)) begin
         rd_data = flags_reg;
      end else if (hit(rd_addr, pes_pkg::OFS_MASKS)) begin
         rd_data = masks_reg;
      end else if (hit(rd_addr, pes_pkg::OFS_STATUS)) begin
         rd_data = status_reg;
      end else if (hit(rd_addr, pes_pkg::OFS_CAUSE)) begin
         rd_data = cause_reg;
      end else if (hit(rd_addr, pes_pkg::OFS_RAIL_ONE)) begin
         rd_data = rail_one_reg;
      end
   end

   logic fault_clr_req;
   logic cause0_clr_req;
   logic flags_wr;
   assign flags_wr = wr.wr_en && hit(wr.addr, pes_pkg::OFS_FLAGS);
   assign fault_clr_req = wr.wr_en && hit(wr.addr, pes_pkg::OFS_FLAGS) && wr.data[pes_pkg::BIT_FAULT];
   assign cause0_clr_req = wr.wr_en && hit(wr.addr, pes_pkg::OFS_CAUSE) && wr.data[pes_pkg::BIT_HEAT];

   property p_fault_set;
      (ev_rise.power_fault || ev_rise.crit_temp)
         |=> flags_reg[pes_pkg::BIT_FAULT] ##1 (flags_reg[pes_pkg::BIT_FAULT] || $past(fault_clr_req));
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault flag not set and held");

   property p_fault_hold;
      flags_reg[pes_pkg::BIT_FAULT] && !fault_clr_req |=> flags_reg[pes_pkg::BIT_FAULT];
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault flag dropped without clear");

   property p_power_off_set;
      (|cause_set) |=> flags_reg[pes_pkg::BIT_POWER_OFF] && (cause_reg != 8'h00);
   endproperty
   a_power_off_set: assert property (p_power_off_set) else $error("shutdown flag not set");

   property p_clear_blocked;
      wr.wr_en && hit(wr.addr, pes_pkg::OFS_FLAGS) && flags_reg[pes_pkg::BIT_POWER_OFF] && (cause_reg != 8'h00)
         |=> flags_reg[pes_pkg::BIT_POWER_OFF];
   endproperty
   a_clear_blocked: assert property (p_clear_blocked) else $error("shutdown flag cleared early");

   property p_power_off_clear;
      flags_wr && wr.data[pes_pkg::BIT_POWER_OFF] && (cause_reg == 8'h00) && !(|cause_set)
         |=> !flags_reg[pes_pkg::BIT_POWER_OFF];
   endproperty
   a_power_off_clear: assert property (p_power_off_clear) else $error("shutdown flag not cleared");

   property p_power_off_hold;
      flags_reg[pes_pkg::BIT_POWER_OFF] && !(flags_wr && wr.data[pes_pkg::BIT_POWER_OFF])
         |=> flags_reg[pes_pkg::BIT_POWER_OFF];
   endproperty
   a_power_off_hold: assert property (p_power_off_hold) else $error("shutdown flag dropped without clear");

   property p_hot_set;
      ev.hot_temp && !ev_prev_reg.hot_temp |=> flags_reg[pes_pkg::BIT_HOT_DIE] && status_reg[pes_pkg::BIT_LIVE_HOT];
   endproperty
   a_hot_set: assert property (p_hot_set) else $error("hot die flag or status missing");

   property p_hot_hold;
      flags_reg[pes_pkg::BIT_HOT_DIE] && !(flags_wr && wr.data[pes_pkg::BIT_HOT_DIE])
         |=> flags_reg[pes_pkg::BIT_HOT_DIE];
   endproperty
   a_hot_hold: assert property (p_hot_hold) else $error("hot die flag dropped without clear");

   property p_mask_write;
      wr.wr_en && hit(wr.addr, pes_pkg::OFS_MASKS) |=> masks_reg == ($past(wr.data) | ~pes_pkg::FLAGS_USED);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

   property p_live_status;
      ##1 status_reg[pes_pkg::BIT_LIVE_HOT] == $past(ev.hot_temp);
   endproperty
   a_live_status: assert property (p_live_status) else $error("live status does not track");

   property p_cause_clear;
      cause0_clr_req && !ev_rise.heat_off |=> !cause_reg[pes_pkg::BIT_HEAT];
   endproperty
   a_cause_clear: assert property (p_cause_clear) else $error("cause bit not cleared");

   property p_ctl_off_zero;
      hit(rd_addr, pes_pkg::OFS_CAUSE) |-> !rd_data[pes_pkg::BIT_CTL_OFF];
   endproperty
   a_ctl_off_zero: assert property (p_ctl_off_zero) else $error("control pin cause reads one");

   property p_uv_cause;
      ev_rise.uv_off |=> cause_reg[pes_pkg::BIT_UV] && flags_reg[pes_pkg::BIT_POWER_OFF];
   endproperty
   a_uv_cause: assert property (p_uv_cause) else $error("undervoltage cause missing");

   property p_oc_cause;
      ev_rise.oc_off |=> cause_reg[pes_pkg::BIT_OC] && flags_reg[pes_pkg::BIT_POWER_OFF];
   endproperty
   a_oc_cause: assert property (p_oc_cause) else $error("overcurrent cause missing");

   property p_heat_cause;
      ev_rise.heat_off |=> cause_reg[pes_pkg::BIT_HEAT] && flags_reg[pes_pkg::BIT_POWER_OFF];
   endproperty
   a_heat_cause: assert property (p_heat_cause) else $error("overheat cause missing");

   property p_identity_stable;
      rail_loaded_reg |=> $stable(identity_reg);
   endproperty
   a_identity_stable: assert property (p_identity_stable) else $error("identity changed");

   property p_rail_write;
      rail_loaded_reg && wr.wr_en && hit(wr.addr, pes_pkg::OFS_RAIL_ONE)
         |=> {rail_one_voltage_code_o, rail_one_passive_fall_o} == $past(wr.data);
   endproperty
   a_rail_write: assert property (p_rail_write) else $error("rail one control not written");

   property p_irq;
      ##1 irq_o == $past(|(flags_reg & ~masks_reg & pes_pkg::FLAGS_USED));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt output mismatch");

   property p_reserved;
      ((flags_reg & ~pes_pkg::FLAGS_USED) == 8'h00) && ((cause_reg & ~pes_pkg::CAUSE_USED) == 8'h00);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   c_fault_irq: cover property (flags_reg[pes_pkg::BIT_FAULT] && !masks_reg[pes_pkg::BIT_FAULT] ##1 irq_o);
   c_shutdown_cleared: cover property (flags_reg[pes_pkg::BIT_POWER_OFF] && cause_reg == 8'h00
                                       ##1 !flags_reg[pes_pkg::BIT_POWER_OFF]);
   c_hot_live: cover property (status_reg[pes_pkg::BIT_LIVE_HOT] && flags_reg[pes_pkg::BIT_HOT_DIE]);
   c_shutdown_irq: cover property (flags_reg[pes_pkg::BIT_POWER_OFF] && !masks_reg[pes_pkg::BIT_POWER_OFF] ##1 irq_o);

endmodule : pes_event_regs

// [hdl/pes_pkg.sv]
package pes_pkg;

   // Register offsets on the serial management port
   localparam logic [7:0] OFS_IDENTITY = 8'h01;
   localparam logic [7:0] OFS_FLAGS = 8'h02;
   localparam logic [7:0] OFS_MASKS = 8'h03;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CAUSE = 8'h05;
   localparam logic [7:0] OFS_RAIL_ONE = 8'h20;

   // Field positions
   localparam int BIT_FAULT = 7;
   localparam int BIT_POWER_OFF = 3;
   localparam int BIT_HOT_DIE = 0;
   localparam int BIT_LIVE_HOT = 0;
   localparam int BIT_CTL_OFF = 3;
   localparam int BIT_UV = 2;
   localparam int BIT_OC = 1;
   localparam int BIT_HEAT = 0;

   // Reset values and implemented-bit masks
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] MASKS_RESET = 8'hFF;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] CAUSE_RESET = 8'h00;
   localparam logic [7:0] FLAGS_USED = 8'h89;
   localparam logic [7:0] CAUSE_USED = 8'h07;

   // Target address on the serial port; value is arbitrary
   localparam logic [6:0] TARGET_ADDR = 7'h5E;

   // Raw event levels from the analog monitors
   typedef struct packed {
      logic power_fault;
      logic crit_temp;
      logic hot_temp;
      logic uv_off;
      logic oc_off;
      logic heat_off;
   } pes_event_t;

   // Register write strobe with its address and data
   typedef struct packed {
      logic wr_en;
      logic [7:0] addr;
      logic [7:0] data;
   } pes_reg_wr_t;

   typedef enum {
      S_IDLE,
      S_ADDR,
      S_AACK,
      S_WRB,
      S_WACK,
      S_RDB,
      S_RACK
   } pes_i2c_state_t;

endpackage : pes_pkg

// [hdl/pes_sync.sv]
`timescale 1ns/1ps
module pes_sync #(
   parameter int WIDTH = 8
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;

   // First stage is read only by the second stage
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_reg <= '0;
         sync_o <= '0;
      end else begin
         meta_reg <= async_i;
         sync_o <= meta_reg;
      end
   end

endmodule : pes_sync

// [hdl/pes_i2c_target.sv]
`timescale 1ns/1ps
module pes_i2c_target (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic [7:0] rd_data_i,
   output logic sda_oe_o,
   output pes_pkg::pes_reg_wr_t wr_o,
   output logic [7:0] rd_addr_o
);

   pes_pkg::pes_i2c_state_t state_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic [3:0] cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [7:0] ptr_reg;
   logic rw_reg;
   logic ptr_phase_reg;
   logic nack_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   assign scl_rise = scl_i & ~scl_prev_reg;
   assign scl_fall = ~scl_i & scl_prev_reg;
   assign start_det = scl_i & scl_prev_reg & sda_prev_reg & ~sda_i;
   assign stop_det = scl_i & scl_prev_reg & ~sda_prev_reg & sda_i;
   assign rd_addr_o = ptr_reg;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_prev_reg <= scl_i;
         sda_prev_reg <= sda_i;
      end
   end

   // Bit sampling on the rising clock edge
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         shift_reg <= 8'h00;
         nack_reg <= 1'b0;
      end else if (scl_rise) begin
         shift_reg <= {shift_reg[6:0], sda_i};
         nack_reg <= sda_i;
      end
   end

   // Protocol sequencer; the pointer auto-increments after each data byte
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= pes_pkg::S_IDLE;
         cnt_reg <= 4'h0;
         tx_reg <= 8'h00;
         ptr_reg <= 8'h00;
         rw_reg <= 1'b0;
         ptr_phase_reg <= 1'b0;
         sda_oe_o <= 1'b0;
         wr_o <= '0;
      end else begin
         wr_o.wr_en <= 1'b0;
         if (start_det) begin
            state_reg <= pes_pkg::S_ADDR;
            cnt_reg <= 4'h0;
            sda_oe_o <= 1'b0;
         end else if (stop_det) begin
            state_reg <= pes_pkg::S_IDLE;
            sda_oe_o <= 1'b0;
         end else if (scl_rise && (state_reg == pes_pkg::S_ADDR || state_reg == pes_pkg::S_WRB ||
                                   state_reg == pes_pkg::S_RDB)) begin
            cnt_reg <= cnt_reg + 4'h1;
         end else if (scl_fall) begin
            case (state_reg)
               pes_pkg::S_ADDR: begin
                  if (cnt_reg == 4'h8) begin
                     if (shift_reg[7:1] == pes_pkg::TARGET_ADDR) begin
                        rw_reg <= shift_reg[0];
                        sda_oe_o <= 1'b1;
                        state_reg <= pes_pkg::S_AACK;
                     end else begin
                        state_reg <= pes_pkg::S_IDLE;
                     end
                  end
               end
               pes_pkg::S_AACK: begin
                  cnt_reg <= 4'h0;
                  if (rw_reg) begin
                     tx_reg <= rd_data_i;
                     sda_oe_o <= ~rd_data_i[7];
                     ptr_reg <= ptr_reg + 8'h01;
                     state_reg <= pes_pkg::S_RDB;
                  end else begin
                     sda_oe_o <= 1'b0;
                     ptr_phase_reg <= 1'b1;
                     state_reg <= pes_pkg::S_WRB;
                  end
               end
               pes_pkg::S_WRB: begin
                  if (cnt_reg == 4'h8) begin
                     sda_oe_o <= 1'b1;
                     state_reg <= pes_pkg::S_WACK;
                     ptr_phase_reg <= 1'b0;
                     if (ptr_phase_reg) begin
                        ptr_reg <= shift_reg;
                     end else begin
                        wr_o.wr_en <= 1'b1;
                        wr_o.addr <= ptr_reg;
                        wr_o.data <= shift_reg;
                        ptr_reg <= ptr_reg + 8'h01;
                     end
                  end
               end
               pes_pkg::S_WACK: begin
                  sda_oe_o <= 1'b0;
                  cnt_reg <= 4'h0;
                  state_reg <= pes_pkg::S_WRB;
               end
               pes_pkg::S_RDB: begin
                  if (cnt_reg == 4'h8) begin
                     sda_oe_o <= 1'b0;
                     state_reg <= pes_pkg::S_RACK;
                  end else begin
                     tx_reg <= {tx_reg[6:0], 1'b0};
                     sda_oe_o <= ~tx_reg[6];
                  end
               end
               pes_pkg::S_RACK: begin
                  if (nack_reg) begin
                     state_reg <= pes_pkg::S_IDLE;
                  end else begin
                     cnt_reg <= 4'h0;
                     tx_reg <= rd_data_i;
                     sda_oe_o <= ~rd_data_i[7];
                     ptr_reg <= ptr_reg + 8'h01;
                     state_reg <= pes_pkg::S_RDB;
                  end
               end
               default: state_reg <= pes_pkg::S_IDLE;
            endcase
         end
      end
   end

endmodule : pes_i2c_target

// [dv/pes_host_model.sv]
`timescale 1ns/1ps
module pes_host_model (
   input wire logic mclk_i,
   input wire logic dev_oe_i,
   output logic scl_o,
   output logic sda_o
);
   logic pull_low;
   int nack_cnt;

   // Open-drain line: once both parties let go, the pull-up brings it high
   assign sda_o = ~(pull_low | dev_oe_i);

   initial begin
      scl_o = 1'b1;
      pull_low = 1'b0;
      nack_cnt = 0;
   end

   // Eight core cycles per phase, four times the two cycles the pin synchroniser needs
   task automatic drive(input logic c, input logic d);
      @(posedge mclk_i);
      scl_o <= c;
      pull_low <= ~d;
      repeat (7) @(posedge mclk_i);
   endtask : drive

   task automatic send_bit(input logic b);
      drive(1'b0, b);
      drive(1'b1, b);
      drive(1'b0, b);
   endtask : send_bit

   // Sampled at the end of the high phase, before the target may move
   task automatic get_bit(output logic b);
      drive(1'b0, 1'b1);
      drive(1'b1, 1'b1);
      b = sda_o;
      drive(1'b0, 1'b1);
   endtask : get_bit

   task automatic start_cond;
      drive(1'b0, 1'b1);
      drive(1'b1, 1'b1);
      drive(1'b1, 1'b0);
      drive(1'b0, 1'b0);
   endtask : start_cond

   task automatic stop_cond;
      drive(1'b0, 1'b0);
      drive(1'b1, 1'b0);
      drive(1'b1, 1'b1);
   endtask : stop_cond

   task automatic send_byte(input logic [7:0] d);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         send_bit(d[i]);
      end
      get_bit(a);
      if (a !== 1'b0) begin
         nack_cnt++;
      end
   endtask : send_byte

   task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
      start_cond();
      send_byte({pes_pkg::TARGET_ADDR, 1'b0});
      send_byte(ofs);
      send_byte(d);
      stop_cond();
   endtask : write_reg

   task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
      start_cond();
      send_byte({pes_pkg::TARGET_ADDR, 1'b0});
      send_byte(ofs);
      start_cond();
      send_byte({pes_pkg::TARGET_ADDR, 1'b1});
      for (int i = 7; i >= 0; i--) begin
         get_bit(d[i]);
      end
      send_bit(1'b1);
      stop_cond();
   endtask : read_reg

   // Causes first, flag in a separate transfer after them
   task automatic clear_power_off(input logic [7:0] causes);
      write_reg(pes_pkg::OFS_CAUSE, causes);
      write_reg(pes_pkg::OFS_FLAGS, 8'h08);
   endtask : clear_power_off
endmodule : pes_host_model

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] ID_VAL = 8'h96; // Arbitrary identity value
   localparam logic [7:0] RAIL_VAL = 8'h82;
   localparam int LIMIT = 90000;
   logic mclk_i;
   logic resetn_i;
   pes_pkg::pes_event_t ev;
   logic scl;
   logic sda;
   logic dev_oe;
   logic dev_sda;
   logic irq;
   logic fall;
   logic [6:0] code;
   logic [7:0] rd;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;

   pes_event_regs dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda), .sda_o(dev_sda),
      .sda_oe_o(dev_oe), .event_i(ev), .otp_identity_i(ID_VAL), .otp_rail_one_i(RAIL_VAL), .irq_o(irq),
      .rail_one_voltage_code_o(code), .rail_one_passive_fall_o(fall));
   pes_host_model host_u (.mclk_i(mclk_i), .dev_oe_i(dev_oe), .scl_o(scl), .sda_o(sda));

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
      host_u.read_reg(ofs, rd);
      chk(rd, exp);
   endtask : rd_chk

   // Level change followed by enough cycles to clear the synchroniser
   task automatic set_ev(input logic [5:0] v);
      @(posedge mclk_i);
      ev <= pes_pkg::pes_event_t'(v);
      repeat (8) @(posedge mclk_i);
   endtask : set_ev

   task automatic t_reset_values;
      rd_chk(pes_pkg::OFS_IDENTITY, ID_VAL);
      rd_chk(pes_pkg::OFS_FLAGS, 8'h00);
      rd_chk(pes_pkg::OFS_MASKS, 8'hFF);
      rd_chk(pes_pkg::OFS_STATUS, 8'h00);
      rd_chk(pes_pkg::OFS_CAUSE, 8'h00);
      rd_chk(pes_pkg::OFS_RAIL_ONE, RAIL_VAL);
      chk({7'h00, irq}, 8'h00);
      chk({7'h00, dev_sda}, 8'h00);
   endtask : t_reset_values

   task automatic t_read_only;
      host_u.write_reg(pes_pkg::OFS_IDENTITY, 8'h69);
      rd_chk(pes_pkg::OFS_IDENTITY, ID_VAL);
      host_u.write_reg(pes_pkg::OFS_STATUS, 8'hFF);
      rd_chk(pes_pkg::OFS_STATUS, 8'h00);
      host_u.write_reg(pes_pkg::OFS_MASKS, 8'h00);
      rd_chk(pes_pkg::OFS_MASKS, 8'h76);
      host_u.write_reg(pes_pkg::OFS_FLAGS, 8'hFF);
      rd_chk(pes_pkg::OFS_FLAGS, 8'h00);
      host_u.write_reg(8'h10, 8'hFF);
      rd_chk(8'h10, 8'h00);
      host_u.write_reg(pes_pkg::OFS_MASKS, 8'hFF);
   endtask : t_read_only

   task automatic t_hot_die;
      set_ev(6'h08);
      chk({7'h00, irq}, 8'h00);
      rd_chk(pes_pkg::OFS_STATUS, 8'h01);
      rd_chk(pes_pkg::OFS_FLAGS, 8'h01);
      host_u.write_reg(pes_pkg::OFS_MASKS, 8'hFE);
      chk({7'h00, irq}, 8'h01);
      set_ev(6'h00);
      rd_chk(pes_pkg::OFS_STATUS, 8'h00);
      rd_chk(pes_pkg::OFS_FLAGS, 8'h01);
      host_u.write_reg(pes_pkg::OFS_FLAGS, 8'h01);
      chk({7'h00, irq}, 8'h00);
      rd_chk(pes_pkg::OFS_FLAGS, 8'h00);
      host_u.write_reg(pes_pkg::OFS_MASKS, 8'hFF);
   endtask : t_hot_die

   // Power fault, then critical temperature
   task automatic t_fault;
      for (int k = 5; k >= 4; k--) begin
         set_ev(6'(6'h01 << k));
         set_ev(6'h00);
         rd_chk(pes_pkg::OFS_FLAGS, 8'h80);
         host_u.write_reg(pes_pkg::OFS_MASKS, 8'h7F);
         chk({7'h00, irq}, 8'h01);
         host_u.write_reg(pes_pkg::OFS_FLAGS, 8'h80);
         rd_chk(pes_pkg::OFS_FLAGS, 8'h00);
         chk({7'h00, irq}, 8'h00);
         host_u.write_reg(pes_pkg::OFS_MASKS, 8'hFF);
      end
   endtask : t_fault

   // Overheat, overcurrent and undervoltage shutdowns in turn
   task automatic t_shutdown;
      host_u.write_reg(pes_pkg::OFS_CAUSE, 8'h08);
      rd_chk(pes_pkg::OFS_CAUSE, 8'h00);
      host_u.write_reg(pes_pkg::OFS_MASKS, 8'hF7);
      for (int k = 0; k < 3; k++) begin
         set_ev(6'(6'h01 << k));
         set_ev(6'h00);
         rd_chk(pes_pkg::OFS_CAUSE, 8'(8'h01 << k));
         rd_chk(pes_pkg::OFS_FLAGS, 8'h08);
         host_u.write_reg(pes_pkg::OFS_FLAGS, 8'h08);
         rd_chk(pes_pkg::OFS_FLAGS, 8'h08);
         chk({7'h00, irq}, 8'h01);
         host_u.clear_power_off(8'(8'h01 << k));
         rd_chk(pes_pkg::OFS_CAUSE, 8'h00);
         rd_chk(pes_pkg::OFS_FLAGS, 8'h00);
         chk({7'h00, irq}, 8'h00);
      end
      host_u.write_reg(pes_pkg::OFS_MASKS, 8'hFF);
   endtask : t_shutdown

   task automatic t_rail_one;
      host_u.write_reg(pes_pkg::OFS_RAIL_ONE, 8'h5B);
      chk({1'b0, code}, 8'h2D);
      chk({7'h00, fall}, 8'h01);
      rd_chk(pes_pkg::OFS_RAIL_ONE, 8'h5B);
   endtask : t_rail_one

   // Reset in mid-run, bus idle: trimmed rail value and reset register values return
   task automatic t_mid_reset;
      @(posedge mclk_i);
      resetn_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      chk({1'b0, code}, {1'b0, RAIL_VAL[7:1]});
      chk({7'h00, fall}, {7'h00, RAIL_VAL[0]});
      t_reset_values();
   endtask : t_mid_reset

   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   // Hang guard, well above the length of all transfers together
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         print_verdict();
      end
   end

   initial begin
      resetn_i = 1'b0;
      ev = '0;
      repeat (16) @(posedge mclk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      t_reset_values();
      t_read_only();
      t_hot_die();
      t_fault();
      t_shutdown();
      t_rail_one();
      t_mid_reset();
      chk(8'(host_u.nack_cnt), 8'h00);
      print_verdict();
   end
endmodule : tb
